//--- pkg/tsr_pkg.sv
package tsr_pkg;

    // Core clock rate, cycles per millisecond
    localparam int CLK_KHZ = 250000;

    // Wait and conversion times in ms
    localparam int POWERUP_MS = 11;
    localparam int SRST_MS = 11;
    localparam int MEAS_LO_MS = 20;
    localparam int MEAS_MID_MS = 80;
    localparam int MEAS_HI_MS = 320;

    // Same times in core cycles
    localparam int POWERUP_CYC = POWERUP_MS * CLK_KHZ;
    localparam int SRST_CYC = SRST_MS * CLK_KHZ;
    localparam int MEAS_LO_CYC = MEAS_LO_MS * CLK_KHZ;
    localparam int MEAS_MID_CYC = MEAS_MID_MS * CLK_KHZ;
    localparam int MEAS_HI_CYC = MEAS_HI_MS * CLK_KHZ;
    localparam int TMR_W = 27;

    // Command byte: address in the top bits, code below
    localparam logic [2:0] CMD_ADDR = 3'h0;
    localparam logic [4:0] CMD_MEAS_T = 5'h03;
    localparam logic [4:0] CMD_MEAS_RH = 5'h05;
    localparam logic [4:0] CMD_STAT_RD = 5'h07;
    localparam logic [4:0] CMD_STAT_WR = 5'h06;
    localparam logic [4:0] CMD_SOFT_RST = 5'h1e;

    // Status byte layout
    localparam int ST_LOWRES = 0;
    localparam int ST_NO_RELOAD = 1;
    localparam int ST_HEATER = 2;
    localparam logic [7:0] STAT_WR_MASK = 8'h07;
    localparam logic [7:0] STAT_RESET = 8'h00;

    // Checksum
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // Bit positions inside one byte frame on the link, and index of the last byte of each readout
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_SECOND = 4'h1;
    localparam logic [1:0] LAST_MEAS = 2'h2;
    localparam logic [1:0] LAST_STAT = 2'h1;

    // Sample and result widths, and bits dropped at low resolution
    localparam int RH_W = 12;
    localparam int T_W = 14;
    localparam int RES_W = 16;
    localparam int RH_DROP = 4;
    localparam int T_DROP = 2;

    typedef enum logic [2:0] {L_IDLE, L_CMD, L_ACK, L_WAIT, L_TX, L_RX, L_RXACK} tsr_link_e;
    typedef enum logic [2:0] {C_POWERUP, C_SLEEP, C_MEAS, C_READY, C_SRST} tsr_core_e;

    typedef struct packed {
        logic [4:0] code;
        logic [7:0] wr_data;
    } tsr_event_s;

    typedef struct packed {
        logic [RH_W-1:0] rh;
        logic [T_W-1:0] temp;
    } tsr_sample_s;

    // One byte into the checksum, MSB first as on the wire
    function automatic logic [7:0] tsr_crc8(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc;
        for (int i = 7; i >= 0; i--)
        begin
            if (c[7] ^ data[i])
                c = (c << 1) ^ CRC_POLY;
            else
                c = c << 1;
        end
        return c;
    endfunction : tsr_crc8

endpackage : tsr_pkg

//--- design/tsr_sync2.sv
`timescale 1ns/100ps
module tsr_sync2
#(
    parameter int W = 1
)
(
    input logic i_clock, // Destination clock
    input logic [W-1:0] i_async, // Level from the other domain
    output logic [W-1:0] o_sync // Synchronised level
);

    logic [W-1:0] meta_r;

    // Two stages; only the second is read by logic
    always_ff @(posedge i_clock)
    begin
        meta_r <= i_async;
        o_sync <= meta_r;
    end

endmodule : tsr_sync2

//--- design/tsr_line_sampler.sv
`timescale 1ns/100ps
module tsr_line_sampler
(
    input logic i_sck, // Link clock
    input logic i_link_nrst, // Link reset, active low
    input logic i_data, // Data wire level
    output logic o_start, // Start pattern seen at this falling edge
    output logic o_rise_bit, // Data sampled at last rising edge
    output logic [7:0] o_rx_byte // Last eight rising-edge samples
);

    logic prev_rise_r;
    logic prev_fall_r;

    // Host bits taken on rising edge
    // Data moves with the link clock, so it is sampled here unsynchronised
    always_ff @(posedge i_sck or negedge i_link_nrst)
    begin
        if (!i_link_nrst)
        begin
            o_rise_bit <= 1'b1;
            o_rx_byte <= 8'h00;
        end
        else
        begin
            o_rise_bit <= i_data;
            o_rx_byte <= {o_rx_byte[6:0], i_data};
        end
    end

    // Remember the previous clock's high-phase levels
    always_ff @(negedge i_sck or negedge i_link_nrst)
    begin
        if (!i_link_nrst)
        begin
            prev_rise_r <= 1'b0;
            prev_fall_r <= 1'b0;
        end
        else
        begin
            prev_rise_r <= o_rise_bit;
            prev_fall_r <= i_data;
        end
    end

    // Start pattern detect
    // Fall while high, one low pulse, rise while high; ordinary bits never change while high
    assign o_start = prev_rise_r & ~prev_fall_r & ~o_rise_bit & i_data;

endmodule : tsr_line_sampler

//--- design/tsr_sensor_top.sv
`timescale 1ns/100ps
module tsr_sensor_top
    import tsr_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_CYC, // Power-up wait
    parameter int SRST_CYCLES = SRST_CYC, // Soft reset wait
    parameter int MEAS_LO_CYCLES = MEAS_LO_CYC, // 8-bit conversion
    parameter int MEAS_MID_CYCLES = MEAS_MID_CYC, // 12-bit conversion
    parameter int MEAS_HI_CYCLES = MEAS_HI_CYC // 14-bit conversion
)
(
    input logic i_clock, // Core clock
    input logic i_nrst, // Synchronous reset, active low
    input logic i_sck, // Serial clock from host
    input logic i_data, // Data wire level
    output logic o_data_out, // Data drive value, always low
    output logic o_data_oe, // Pull data low when high
    input tsr_sample_s i_sample, // Converter samples
    output logic o_busy, // Not in sleep
    output logic o_heater // Heater enable
);

    // Core domain state
    tsr_core_e state_r;
    logic [TMR_W-1:0] tmr_r;
    logic [7:0] status_r;
    logic [RES_W-1:0] result_r;
    logic meas_rh_r;
    logic core_ok_r;
    logic link_nrst_r;
    logic ev_seen_r;
    logic ev_s;
    logic drive_s;
    logic rd_s;
    logic ev_pulse;
    logic [TMR_W-1:0] meas_cyc;
    logic [RES_W-1:0] res_nxt;

    // Link domain state
    tsr_link_e lstate_r;
    logic [3:0] cnt_r;
    logic [4:0] cmd_r;
    logic drive_r;
    logic [7:0] tx_sh_r;
    logic [1:0] byte_idx_r;
    logic [1:0] last_idx_r;
    logic [7:0] crc_r;
    tsr_event_s ev_r;
    logic ev_tgl_r;
    logic reading_r;
    logic core_ok_s;
    logic start;
    logic rise_bit;
    logic [7:0] rx_byte;
    logic cmd_known;
    logic cmd_take;
    logic host_ack;
    logic more;
    logic [1:0] nxt_idx;
    logic [7:0] nb;
    logic [7:0] msb;

    // Core: link reset follows the core reset
    // Link clock may stand still, so its logic is cleared asynchronously
    always_ff @(posedge i_clock)
    begin
        link_nrst_r <= i_nrst;
    end

    // Crossings into the core
    tsr_sync2 #(.W(3)) u_core_sync (
        .i_clock(i_clock),
        .i_async({ev_tgl_r, drive_r, reading_r}),
        .o_sync({ev_s, drive_s, rd_s})
    );

    // Crossing into the link
    tsr_sync2 #(.W(1)) u_link_sync (
        .i_clock(i_sck),
        .i_async(core_ok_r),
        .o_sync(core_ok_s)
    );

    tsr_line_sampler u_sampler (
        .i_sck(i_sck),
        .i_link_nrst(link_nrst_r),
        .i_data(i_data),
        .o_start(start),
        .o_rise_bit(rise_bit),
        .o_rx_byte(rx_byte)
    );

    // Event edge from the link toggle
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
            ev_seen_r <= 1'b0;
        else
            ev_seen_r <= ev_s;
    end
    assign ev_pulse = ev_s ^ ev_seen_r;

    always_comb
    begin
        meas_cyc = TMR_W'(MEAS_HI_CYCLES - 1);
        if (ev_r.code == CMD_MEAS_RH)
            meas_cyc = status_r[ST_LOWRES] ? TMR_W'(MEAS_LO_CYCLES - 1) : TMR_W'(MEAS_MID_CYCLES - 1);
        else if (status_r[ST_LOWRES])
            meas_cyc = TMR_W'(MEAS_MID_CYCLES - 1);
    end

    always_comb
    begin
        if (meas_rh_r)
            res_nxt = status_r[ST_LOWRES] ? RES_W'(i_sample.rh >> RH_DROP) : RES_W'(i_sample.rh);
        else
            res_nxt = status_r[ST_LOWRES] ? RES_W'(i_sample.temp >> T_DROP) : RES_W'(i_sample.temp);
    end

    // Core sequencer
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            state_r <= C_POWERUP;
            tmr_r <= TMR_W'(POWERUP_CYCLES - 1);
        end
        else
        begin
            case (state_r)
                C_POWERUP, C_SRST, C_MEAS:
                begin
                    if (tmr_r == '0)
                        state_r <= (state_r == C_MEAS) ? C_READY : C_SLEEP;
                    else
                        tmr_r <= tmr_r - 1'b1;
                end
                C_SLEEP:
                begin
                    if (ev_pulse)
                    begin
                        if (ev_r.code == CMD_MEAS_RH || ev_r.code == CMD_MEAS_T)
                        begin
                            state_r <= C_MEAS;
                            tmr_r <= meas_cyc;
                        end
                        else if (ev_r.code == CMD_SOFT_RST)
                        begin
                            state_r <= C_SRST;
                            tmr_r <= TMR_W'(SRST_CYCLES - 1);
                        end
                    end
                end
                C_READY:
                begin
                    if (rd_s)
                        state_r <= C_SLEEP;
                end
                default:
                    state_r <= C_SLEEP;
            endcase
        end
    end

    // Kind of the running conversion
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
            meas_rh_r <= 1'b0;
        else if (state_r == C_SLEEP && ev_pulse)
            meas_rh_r <= (ev_r.code == CMD_MEAS_RH);
    end

    // Result held until the next conversion ends
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
            result_r <= '0;
        else if (state_r == C_MEAS && tmr_r == '0)
            result_r <= res_nxt;
    end

    // Status byte; only the writable bits are kept
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
            status_r <= STAT_RESET;
        else if (state_r == C_SLEEP && ev_pulse)
        begin
            if (ev_r.code == CMD_STAT_WR)
                status_r <= ev_r.wr_data & STAT_WR_MASK;
            else if (ev_r.code == CMD_SOFT_RST)
                status_r <= STAT_RESET;
        end
    end

    // Pin and flag outputs, all registered
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            o_data_out <= 1'b0;
            o_data_oe <= 1'b0;
            o_busy <= 1'b1;
            o_heater <= 1'b0;
            core_ok_r <= 1'b0;
        end
        else
        begin
            o_data_out <= 1'b0;
            // Ready pulls data low until readout takes over
            // Ready drops as soon as the readout flag arrives, so bit 14 is not a cycle late
            o_data_oe <= ((state_r == C_READY) & ~rd_s) | drive_s;
            o_busy <= (state_r != C_SLEEP);
            o_heater <= status_r[ST_HEATER];
            core_ok_r <= (state_r == C_SLEEP);
        end
    end

    // Link decode
    // Address must be zero
    // Other bus addresses fall through unanswered
    assign cmd_known = (rx_byte[4:0] == CMD_MEAS_T) || (rx_byte[4:0] == CMD_MEAS_RH)
        || (rx_byte[4:0] == CMD_STAT_RD) || (rx_byte[4:0] == CMD_STAT_WR)
        || (rx_byte[4:0] == CMD_SOFT_RST);
    // Refused while the core is not asleep
    assign cmd_take = (rx_byte[7:5] == CMD_ADDR) && cmd_known && core_ok_s;
    assign host_ack = ~rise_bit;
    assign more = (byte_idx_r != last_idx_r);
    assign nxt_idx = byte_idx_r + 2'h1;
    assign nb = (nxt_idx == last_idx_r) ? crc_r : result_r[7:0];
    assign msb = result_r[RES_W-1:8];

    // Link sequencer, stepped only by falling edges
    always_ff @(negedge i_sck or negedge link_nrst_r)
    begin
        if (!link_nrst_r)
        begin
            lstate_r <= L_IDLE;
            cnt_r <= BIT_FIRST;
            cmd_r <= '0;
            ev_r <= '0;
            ev_tgl_r <= 1'b0;
            reading_r <= 1'b0;
        end
        // A start always restarts the interface
        else if (start)
        begin
            lstate_r <= L_CMD;
            cnt_r <= BIT_FIRST;
            reading_r <= 1'b0;
        end
        else
        begin
            case (lstate_r)
                L_IDLE:
                    lstate_r <= L_IDLE;
                L_CMD:
                begin
                    if (cnt_r == BIT_LAST)
                    begin
                        lstate_r <= cmd_take ? L_ACK : L_IDLE;
                        cmd_r <= rx_byte[4:0];
                    end
                    else
                        cnt_r <= cnt_r + 1'b1;
                end
                L_ACK:
                begin
                    cnt_r <= BIT_FIRST;
                    ev_r.code <= cmd_r;
                    if (cmd_r == CMD_STAT_RD)
                        lstate_r <= L_TX;
                    else if (cmd_r == CMD_STAT_WR)
                        lstate_r <= L_RX;
                    else
                    begin
                        ev_tgl_r <= ~ev_tgl_r;
                        lstate_r <= (cmd_r == CMD_SOFT_RST) ? L_IDLE : L_WAIT;
                    end
                end
                L_WAIT:
                begin
                    // First clock after ready; bit 7 was shown by the ready low
                    lstate_r <= L_TX;
                    cnt_r <= BIT_SECOND;
                    reading_r <= 1'b1;
                end
                L_TX:
                begin
                    // Stop on missing ack or after the last byte
                    if (cnt_r == BIT_ACK)
                    begin
                        if (host_ack && more)
                            cnt_r <= BIT_FIRST;
                        else
                        begin
                            lstate_r <= L_IDLE;
                            reading_r <= 1'b0;
                        end
                    end
                    else
                        cnt_r <= cnt_r + 1'b1;
                end
                L_RX:
                begin
                    if (cnt_r == BIT_LAST)
                    begin
                        ev_r.wr_data <= rx_byte;
                        lstate_r <= L_RXACK;
                    end
                    else
                        cnt_r <= cnt_r + 1'b1;
                end
                L_RXACK:
                begin
                    ev_tgl_r <= ~ev_tgl_r;
                    lstate_r <= L_IDLE;
                end
                default:
                    lstate_r <= L_IDLE;
            endcase
        end
    end

    // Sensor drive changes only on falling edges
    // Open drain: the line is only ever pulled low
    always_ff @(negedge i_sck or negedge link_nrst_r)
    begin
        if (!link_nrst_r)
        begin
            drive_r <= 1'b0;
            tx_sh_r <= 8'h00;
            byte_idx_r <= 2'h0;
            last_idx_r <= LAST_MEAS;
            crc_r <= CRC_INIT;
        end
        else if (start)
            drive_r <= 1'b0;
        else
        begin
            case (lstate_r)
                L_CMD:
                begin
                    // Ack after the 8th falling edge
                    // Checksum starts with the command byte
                    if (cnt_r == BIT_LAST && cmd_take)
                    begin
                        drive_r <= 1'b1;
                        crc_r <= tsr_crc8(CRC_INIT, rx_byte);
                    end
                end
                L_ACK:
                begin
                    // Release after the 9th falling edge; a status read drives status bit 7 instead
                    drive_r <= 1'b0;
                    byte_idx_r <= 2'h0;
                    last_idx_r <= LAST_MEAS;
                    if (cmd_r == CMD_STAT_RD)
                    begin
                        last_idx_r <= LAST_STAT;
                        tx_sh_r <= status_r;
                        drive_r <= ~status_r[7];
                        crc_r <= tsr_crc8(crc_r, status_r);
                    end
                end
                L_WAIT:
                begin
                    tx_sh_r <= msb << 1;
                    drive_r <= ~msb[6];
                    crc_r <= tsr_crc8(crc_r, msb);
                end
                L_TX:
                begin
                    if (cnt_r < BIT_LAST)
                    begin
                        tx_sh_r <= tx_sh_r << 1;
                        drive_r <= ~tx_sh_r[6];
                    end
                    // Let the host ack in the 9th clock
                    else if (cnt_r == BIT_LAST)
                        drive_r <= 1'b0;
                    else if (host_ack && more)
                    begin
                        tx_sh_r <= nb;
                        drive_r <= ~nb[7];
                        byte_idx_r <= nxt_idx;
                        if (nxt_idx != last_idx_r)
                            crc_r <= tsr_crc8(crc_r, nb);
                    end
                end
                L_RX:
                begin
                    if (cnt_r == BIT_LAST)
                        drive_r <= 1'b1;
                end
                default:
                    drive_r <= 1'b0;
            endcase
        end
    end

endmodule : tsr_sensor_top

//--- testbench/tsr_host_model.sv
`timescale 1ns/100ps
module tsr_host_model
(
    output logic o_sck, // Serial clock, idles low
    output logic o_pull, // High pulls the data wire low
    input wire logic i_data // Resolved data wire
);
    logic [8:0] rx_r;
    event rx_ev;

    // Clock stands still and the wire is released between frames
    initial
    begin
        o_sck = 1'b0;
        o_pull = 1'b0;
    end

    task automatic start();
        #7.7 o_sck = 1'b1;
        #15 o_pull = 1'b1;
        #15 o_sck = 1'b0;
        #15 o_sck = 1'b1;
        #15 o_pull = 1'b0;
        #15 o_sck = 1'b0;
    endtask : start

    // Nine clocks, bits set after the fall
    task automatic io(input logic [7:0] tx, input logic hack);
        logic [8:0] b;
        b = {tx, ~hack};
        for (int i = 8; i >= 0; i--)
        begin
            #2 o_pull = ~b[i]; // Pulls low or releases, never drives high
            #13 o_sck = 1'b1;
            rx_r[i] = i_data;
            #15 o_sck = 1'b0;
        end
        #2 o_pull = 1'b0;
        -> rx_ev;
    endtask : io
endmodule : tsr_host_model

//--- testbench/tsr_sensor_sva.sv
`timescale 1ns/100ps
module tsr_sensor_sva
#(
    parameter int POWERUP_CYCLES = 200, // Power-up wait
    parameter int MEAS_LO_CYCLES = 300 // Shortest conversion
)
(
    input wire logic i_clock, // Core clock
    input wire logic i_nrst, // Reset, active low
    input wire logic i_sck, // Serial clock
    input wire logic o_data_out, // Drive value
    input wire logic o_data_oe, // Pull-low enable
    input wire logic o_busy, // Not asleep
    input wire logic o_heater // Heater level
);
    logic sck_r;
    logic [6:0] since_fall_r;
    int up_cnt_r;
    int busy_cnt_r;

    // Link falls seen from the core clock; saturates so idle gaps read large
    always_ff @(posedge i_clock)
    begin
        sck_r <= i_sck;
        if (!i_nrst || (since_fall_r == 7'h7f && !(sck_r && !i_sck)))
            since_fall_r <= 7'h7f;
        else if (sck_r && !i_sck)
            since_fall_r <= 7'h00;
        else
            since_fall_r <= since_fall_r + 7'h01;
    end

    // Cycles since reset release
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
            up_cnt_r <= 0;
        else if (up_cnt_r < POWERUP_CYCLES + 8)
            up_cnt_r <= up_cnt_r + 1;
    end

    // Cycles since the core left sleep
    always_ff @(posedge i_clock)
    begin
        if (!o_busy)
            busy_cnt_r <= 0;
        else if (busy_cnt_r < MEAS_LO_CYCLES + 8)
            busy_cnt_r <= busy_cnt_r + 1;
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);

    // Data pulled low while the link clock has been idle a while
    sequence ready_seen;
        $rose(o_data_oe) && o_busy && (since_fall_r > 7'h28);
    endsequence

    sequence sck_held;
        i_sck && $past(i_sck);
    endsequence

    reset_state_a: assert property (disable iff (1'b0) !i_nrst |=> !o_data_oe && o_busy && !o_heater)
        else $error("outputs wrong after reset");
    powerup_hold_a: assert property (up_cnt_r < POWERUP_CYCLES - 3 |-> o_busy && !o_data_oe)
        else $error("sensor awake too early");
    powerup_end_a: assert property (up_cnt_r == POWERUP_CYCLES + 4 |-> !o_busy)
        else $error("sensor never reached sleep");
    high_stable_a: assert property (sck_held |-> $stable(o_data_oe))
        else $error("data changed while clock high");
    fall_edge_a: assert property ($fell(o_data_oe) |-> since_fall_r <= 7'h06)
        else $error("data release not after a clock fall");
    drive_low_a: assert property (o_data_oe |-> !o_data_out)
        else $error("sensor drives the wire high");
    conv_time_a: assert property (ready_seen |-> busy_cnt_r >= MEAS_LO_CYCLES)
        else $error("result ready too early");
    ready_hold_a: assert property (ready_seen |=> o_data_oe [*8])
        else $error("ready level not held");
endmodule : tsr_sensor_sva

bind tsr_sensor_top tsr_sensor_sva #(.POWERUP_CYCLES(POWERUP_CYCLES), .MEAS_LO_CYCLES(MEAS_LO_CYCLES)) u_sva
(
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_sck(i_sck),
    .o_data_out(o_data_out),
    .o_data_oe(o_data_oe),
    .o_busy(o_busy),
    .o_heater(o_heater)
);

//--- testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top
    import tsr_pkg::*;
;
    logic i_clock, i_nrst, o_oe, o_dout, o_busy, o_heater, sck, pull;
    tsr_sample_s samp;
    wire data_w;
    int seed, err_total, n_compared;
    logic [8:0] exp_q [$];
    logic [7:0] bad [5] = '{8'h25, 8'h85, 8'h01, 8'h0a, 8'h1c};

    // Open-drain wire with pull-up
    assign data_w = ~(o_oe | pull);

    tsr_sensor_top #(.POWERUP_CYCLES(200), .SRST_CYCLES(200), .MEAS_LO_CYCLES(300),
        .MEAS_MID_CYCLES(400), .MEAS_HI_CYCLES(500)) dut
    (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_sck(sck), .i_data(data_w), .o_data_out(o_dout),
        .o_data_oe(o_oe), .i_sample(samp), .o_busy(o_busy), .o_heater(o_heater)
    );

    tsr_host_model u_host (.o_sck(sck), .o_pull(pull), .i_data(data_w));

    // Core clock, 250 MHz
    initial
    begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end

    task automatic fail(input string msg);
        err_total++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask : fail

    task automatic chk9(input logic [8:0] exp, input logic [8:0] act);
        n_compared++;
        if (act !== exp)
            fail("link byte mismatch");
    endtask : chk9

    task automatic chk1(input logic exp, input logic act);
        n_compared++;
        if (act !== exp)
            fail("level mismatch");
    endtask : chk1

    task automatic print_verdict();
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // Own checksum model, wire order
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
            r = (r[7] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        return r;
    endfunction : crc8

    // Bounded wait for data-ready (rdy) or for sleep
    task automatic wait_sig(input bit rdy);
        int n;
        n = 0;
        while ((rdy ? data_w !== 1'b0 : o_busy !== 1'b0) && n < 3000)
        begin
            @(posedge i_clock);
            n++;
        end
        if (n >= 3000)
            fail("wait timed out");
    endtask : wait_sig

    task automatic xfer(input logic [7:0] tx, input logic hack, input logic [8:0] exp);
        exp_q.push_back(exp);
        u_host.io(tx, hack);
    endtask : xfer

    task automatic cmd(input logic [7:0] c, input logic ackb);
        wait_sig(0);
        u_host.start();
        xfer(c, 1'b0, {c, ackb});
    endtask : cmd

    task automatic stat_rd(input logic [7:0] st);
        cmd({CMD_ADDR, CMD_STAT_RD}, 1'b0);
        xfer(8'hff, 1'b1, {st, 1'b0});
        xfer(8'hff, 1'b1, {crc8(crc8(CRC_INIT, {CMD_ADDR, CMD_STAT_RD}), st), 1'b0});
    endtask : stat_rd

    task automatic measure(input logic [4:0] code, input bit lowres, input bit use_crc);
        logic [15:0] res;
        logic [7:0] c;
        @(posedge i_clock);
        samp <= 26'($random(seed));
        @(posedge i_clock);
        cmd({CMD_ADDR, code}, 1'b0);
        repeat (5) @(posedge i_clock);
        wait_sig(1);
        repeat (50) @(posedge i_clock);
        if (code == CMD_MEAS_RH)
            res = lowres ? {8'h00, samp.rh[11:4]} : {4'h0, samp.rh};
        else
            res = lowres ? {4'h0, samp.temp[13:2]} : {2'h0, samp.temp};
        c = crc8(crc8(CRC_INIT, {CMD_ADDR, code}), res[15:8]);
        xfer(8'hff, 1'b1, {res[15:8], 1'b0});
        xfer(8'hff, use_crc, {res[7:0], ~use_crc});
        if (use_crc)
            xfer(8'hff, 1'b1, {crc8(c, res[7:0]), 1'b0});
        wait_sig(0);
        // Host idles nine times the longest conversion to stay under a tenth
        repeat (4500) @(posedge i_clock);
    endtask : measure

    // Monitor: every finished host frame takes the oldest expectation
    initial
    forever
    begin
        @(u_host.rx_ev);
        if (exp_q.size() == 0)
            fail("unexpected frame");
        else
            chk9(exp_q.pop_front(), u_host.rx_r);
    end

    // Watchdog well beyond the planned run
    initial
    begin
        #200000;
        fail("watchdog expired");
        print_verdict();
    end

    initial
    begin
        seed = 78;
        i_nrst = 1'b0;
        samp = '0;
        repeat (20) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(posedge i_clock);
        u_host.start();
        xfer(8'h05, 1'b0, 9'h00b);
        chk1(1'b1, o_busy);
        foreach (bad[i])
            cmd(bad[i], 1'b1);
        chk1(1'b0, o_busy);
        measure(CMD_MEAS_RH, 1'b0, 1'b1);
        measure(CMD_MEAS_T, 1'b0, 1'b1);
        cmd({CMD_ADDR, CMD_STAT_WR}, 1'b0);
        xfer(8'hfd, 1'b0, 9'h1fa);
        // Status lands a few core cycles after the last link edge
        repeat (8) @(posedge i_clock);
        wait_sig(0);
        chk1(1'b1, o_heater);
        stat_rd(8'h05);
        xfer(8'hff, 1'b0, 9'h1ff);
        stat_rd(8'h05);
        measure(CMD_MEAS_RH, 1'b1, 1'b0);
        measure(CMD_MEAS_T, 1'b1, 1'b1);
        cmd({CMD_ADDR, CMD_SOFT_RST}, 1'b0);
        // Busy rises only after the event crosses into the core
        repeat (8) @(posedge i_clock);
        chk1(1'b1, o_busy);
        wait_sig(0);
        chk1(1'b0, o_heater);
        stat_rd(8'h00);
        repeat (10) @(posedge i_clock);
        if (exp_q.size() != 0)
            fail("frames missing");
        print_verdict();
    end
endmodule : tb_top
